// ===== src/mpet_map.vh
// Register map, field positions, reset values and timing constants of the echo timer.
`ifndef MPET_MAP_VH
`define MPET_MAP_VH
////////////////////////////////////////////////////////////////////////////////
// Register byte offsets.
`define MPET_OFF_LATCH    8'h00
`define MPET_OFF_CTRL     8'h04
`define MPET_OFF_FMT      8'h08
`define MPET_OFF_WIDTH    8'h0c
`define MPET_OFF_DIV      8'h10
`define MPET_OFF_FREQ     8'h14
`define MPET_OFF_STAT     8'h18
////////////////////////////////////////////////////////////////////////////////
// Control and format register fields.
`define MPET_CTRL_OUTEN   0
`define MPET_CTRL_TM_LO   1
`define MPET_CTRL_TM_HI   2
`define MPET_TMODE_ECHO   2'h1
`define MPET_FMT_PULSE_BIT 3
////////////////////////////////////////////////////////////////////////////////
// Status register fields.
`define MPET_STAT_VALID   0
`define MPET_STAT_TMO     1
`define MPET_STAT_BUSY    2
`define MPET_STAT_NOCAPT  3
`define MPET_STAT_PULSE   4
////////////////////////////////////////////////////////////////////////////////
// Reset values.
`define MPET_RST_OUTEN    1'h0
`define MPET_RST_TMODE    2'h0
`define MPET_RST_FMT      4'h0
`define MPET_RST_WIDTH    16'h0005
`define MPET_RST_DIV      16'h0020
`define MPET_RST_FREQ     24'h000000
`define MPET_RST_LATCH    24'h000000
////////////////////////////////////////////////////////////////////////////////
// Timing: system clock and echo timer rates, and the latch layout.
`define MPET_CLK_HZ       100000000
`define MPET_TIMER_HZ     600000000
`define MPET_TIMER_STEP   (`MPET_TIMER_HZ / `MPET_CLK_HZ)
`define MPET_TIMER_MAX    24'hffffff
`define MPET_LATCH_FILL   8'h00
`endif

// ===== src/mpet_pulse_gen.v
// Pulse clock divider and excitation pulse shaper.
`timescale 1ns/1ns
`include "mpet_map.vh"
module mpet_pulse_gen (
  // Clock and reset.
  input  wire        clk,
  input  wire        nrst,
  // Settings.
  input  wire [15:0] div,
  input  wire [15:0] width,
  // Request and events.
  input  wire        fire,
  output reg         tick_q,
  output reg         pulse_q,
  output reg         fall_q
);
////////////////////////////////////////////////////////////////////////////////
reg  [15:0] div_cnt_q;
reg  [15:0] wcnt_q;
reg         pend_q;
wire [15:0] div_last;
wire        tick_w;

assign div_last = (div == 16'h0000) ? 16'h0000 : div - 16'h0001;
assign tick_w   = (div_cnt_q >= div_last);

// The pulse clock is the system clock divided by the divider setting; a setting of zero divides by one.
always @(posedge clk or negedge nrst) begin
  if (!nrst) begin
    div_cnt_q <= 16'h0000;
    tick_q    <= 1'b0;
  end else begin
    tick_q <= tick_w;
    if (tick_w) begin
      div_cnt_q <= 16'h0000;
    end else begin
      div_cnt_q <= div_cnt_q + 16'h0001;
    end
  end
end

////////////////////////////////////////////////////////////////////////////////
// A request starts a pulse on the next pulse clock tick that lasts width ticks.
always @(posedge clk or negedge nrst) begin
  if (!nrst) begin
    pend_q  <= 1'b0;
    pulse_q <= 1'b0;
    wcnt_q  <= 16'h0000;
    fall_q  <= 1'b0;
  end else begin
    fall_q <= 1'b0;
    if (fire) begin
      pend_q <= 1'b1;
    end
    if (tick_w) begin
      if (pulse_q) begin
        wcnt_q <= wcnt_q - 16'h0001;
        if (wcnt_q == 16'h0001) begin
          pulse_q <= 1'b0;
          fall_q  <= 1'b1;
        end
      end else if (pend_q && width != 16'h0000) begin
        pend_q  <= fire;
        pulse_q <= 1'b1;
        wcnt_q  <= width;
      end else if (pend_q) begin
        pend_q <= fire;
      end
    end
  end
end

endmodule // mpet_pulse_gen

// ===== src/mpet_pulse_echo_timer.v
// Pulse-echo timer channel for an externally excited displacement transducer.
//
// The register addresses and the strobed register port are this design's own decisions.
`timescale 1ns/1ns
`include "mpet_map.vh"
module mpet_pulse_echo_timer (
  // Clock and reset.
  input  wire        clk,
  input  wire        nrst,
  // Register port.
  input  wire [7:0]  addr,
  input  wire [31:0] wdata,
  input  wire        wr,
  input  wire        rd,
  output reg  [31:0] rdata_q,
  // Servo interrupt strobe.
  input  wire        servo_irq,
  // Echo input pair.
  input  wire        echo_input_pos,
  input  wire        echo_input_neg,
  // Excitation output pair and its output enable.
  output reg         pulse_frequency_output_pos_q,
  output reg         pulse_frequency_output_neg_q,
  output reg         pulse_frequency_output_oe_q,
  // Channel state.
  output reg         capture_unavailable_q,
  output reg         position_valid_q
);
////////////////////////////////////////////////////////////////////////////////
// Timer increment per system clock, derived from the two rates.
localparam integer TIMER_RATIO = `MPET_TIMER_STEP;
localparam [23:0]  TIMER_STEP  = TIMER_RATIO[23:0];
localparam [23:0] TIMER_MAX  = `MPET_TIMER_MAX;

// Software settings.
reg         phase_d_output_enable_q;
reg  [1:0]  channel_timer_function_q;
reg  [3:0]  phase_output_format_q;
reg  [15:0] pulse_width_setting_q;
reg  [15:0] pulse_clock_divider_q;
reg  [23:0] freq_cmd_q;

// Echo path.
reg         echo_pos_s1_q;
reg         echo_pos_s2_q;
reg         echo_neg_s1_q;
reg         echo_neg_s2_q;
reg         echo_lvl_q;
wire        echo_lvl_w;
wire        echo_rise_w;

// Timer and latch.
reg  [23:0] timer_q;
reg  [23:0] timer_d;
reg         counting_q;
reg         counting_d;
reg  [23:0] echo_time_latch_q;
reg  [23:0] latch_d;
reg         latch_evt_w;
reg         tmo_evt_w;

// Sticky status.
reg         stat_valid_q;
reg         stat_tmo_q;

// Pulse frequency accumulator.
reg  [23:0] freq_acc_q;
reg         freq_carry_q;
wire [24:0] freq_sum_w;

// Pulse generator links.
wire        echo_mode_w;
wire        pulse_mode_w;
wire        fire_w;
wire        tick_w;
wire        pulse_w;
wire        fall_w;

// Register decode.
wire        wr_ctrl_w;
wire        wr_fmt_w;
wire        wr_width_w;
wire        wr_div_w;
wire        wr_freq_w;
wire        wr_stat_w;
reg  [31:0] rd_mux_w;

////////////////////////////////////////////////////////////////////////////////
// Mode decode.
assign echo_mode_w = (channel_timer_function_q == `MPET_TMODE_ECHO);
assign pulse_mode_w = phase_output_format_q[`MPET_FMT_PULSE_BIT];

////////////////////////////////////////////////////////////////////////////////
// Register writes.
assign wr_ctrl_w  = wr && (addr == `MPET_OFF_CTRL);
assign wr_fmt_w   = wr && (addr == `MPET_OFF_FMT);
assign wr_width_w = wr && (addr == `MPET_OFF_WIDTH);
assign wr_div_w   = wr && (addr == `MPET_OFF_DIV);
assign wr_freq_w  = wr && (addr == `MPET_OFF_FREQ);
assign wr_stat_w  = wr && (addr == `MPET_OFF_STAT);

always @(posedge clk or negedge nrst) begin
  if (!nrst) begin
    phase_d_output_enable_q  <= `MPET_RST_OUTEN;
    channel_timer_function_q <= `MPET_RST_TMODE;
    phase_output_format_q    <= `MPET_RST_FMT;
    pulse_width_setting_q    <= `MPET_RST_WIDTH;
    pulse_clock_divider_q    <= `MPET_RST_DIV;
    freq_cmd_q               <= `MPET_RST_FREQ;
  end else begin
    if (wr_ctrl_w) begin
      phase_d_output_enable_q  <= wdata[`MPET_CTRL_OUTEN];
      channel_timer_function_q <= wdata[`MPET_CTRL_TM_HI:`MPET_CTRL_TM_LO];
    end
    if (wr_fmt_w) begin
      phase_output_format_q <= wdata[3:0];
    end
    if (wr_width_w) begin
      pulse_width_setting_q <= wdata[15:0];
    end
    if (wr_div_w) begin
      pulse_clock_divider_q <= wdata[15:0];
    end
    if (wr_freq_w) begin
      freq_cmd_q <= wdata[23:0];
    end
  end
end

////////////////////////////////////////////////////////////////////////////////
// Pulse frequency accumulator, used only outside transducer mode.
assign freq_sum_w = {1'b0, freq_acc_q} + {1'b0, freq_cmd_q};

always @(posedge clk or negedge nrst) begin
  if (!nrst) begin
    freq_acc_q   <= 24'h000000;
    freq_carry_q <= 1'b0;
  end else begin
    freq_carry_q <= 1'b0;
    if (echo_mode_w) begin
      freq_acc_q <= 24'h000000;
    end else if (tick_w) begin
      freq_acc_q   <= freq_sum_w[23:0];
      freq_carry_q <= freq_sum_w[24];
    end
  end
end

// Transducer mode fires on the servo interrupt, gated by the output enable and the pulse format bit.
assign fire_w = phase_d_output_enable_q && pulse_mode_w &&
                (echo_mode_w ? servo_irq : freq_carry_q);

////////////////////////////////////////////////////////////////////////////////
// Pulse clock divider and pulse shaper.
mpet_pulse_gen u_pulse_gen (
  .clk    (clk),
  .nrst   (nrst),
  .div    (pulse_clock_divider_q),
  .width  (pulse_width_setting_q),
  .fire   (fire_w),
  .tick_q (tick_w),
  .pulse_q(pulse_w),
  .fall_q (fall_w)
);

////////////////////////////////////////////////////////////////////////////////
// Differential excitation drive, gated by the output enable.
always @(posedge clk or negedge nrst) begin
  if (!nrst) begin
    pulse_frequency_output_pos_q <= 1'b0;
    pulse_frequency_output_neg_q <= 1'b0;
    pulse_frequency_output_oe_q  <= 1'b0;
  end else begin
    pulse_frequency_output_oe_q  <= phase_d_output_enable_q;
    pulse_frequency_output_pos_q <= phase_d_output_enable_q && pulse_w;
    pulse_frequency_output_neg_q <= phase_d_output_enable_q && !pulse_w;
  end
end

////////////////////////////////////////////////////////////////////////////////
// Echo pair synchroniser and rising edge detect.
always @(posedge clk or negedge nrst) begin
  if (!nrst) begin
    echo_pos_s1_q <= 1'b0;
    echo_pos_s2_q <= 1'b0;
    echo_neg_s1_q <= 1'b1;
    echo_neg_s2_q <= 1'b1;
    echo_lvl_q    <= 1'b0;
  end else begin
    echo_pos_s1_q <= echo_input_pos;
    echo_pos_s2_q <= echo_pos_s1_q;
    echo_neg_s1_q <= echo_input_neg;
    echo_neg_s2_q <= echo_neg_s1_q;
    echo_lvl_q    <= echo_lvl_w;
  end
end

// The pair reads high when the positive leg is above the negative leg.
assign echo_lvl_w  = echo_pos_s2_q && !echo_neg_s2_q;
assign echo_rise_w = echo_lvl_w && !echo_lvl_q;

////////////////////////////////////////////////////////////////////////////////
// Echo timer: clear on the pulse fall, count, latch on the echo edge.
always @* begin
  timer_d     = timer_q;
  counting_d  = counting_q;
  latch_d     = echo_time_latch_q;
  latch_evt_w = 1'b0;
  tmo_evt_w   = 1'b0;
  if (!echo_mode_w) begin
    counting_d = 1'b0;
  end else if (fall_w) begin
    timer_d    = 24'h000000;
    counting_d = 1'b1;
    tmo_evt_w  = counting_q;
  end else if (counting_q) begin
    if (echo_rise_w) begin
      latch_d     = timer_q;
      latch_evt_w = 1'b1;
      counting_d  = 1'b0;
    end else if (timer_q > TIMER_MAX - TIMER_STEP) begin
      timer_d = TIMER_MAX;
    end else begin
      timer_d = timer_q + TIMER_STEP;
    end
  end
end

always @(posedge clk or negedge nrst) begin
  if (!nrst) begin
    timer_q           <= 24'h000000;
    counting_q        <= 1'b0;
    echo_time_latch_q <= `MPET_RST_LATCH;
  end else begin
    timer_q           <= timer_d;
    counting_q        <= counting_d;
    echo_time_latch_q <= latch_d;
  end
end

////////////////////////////////////////////////////////////////////////////////
// Sticky status flags; a new event wins over a write-one clear.
always @(posedge clk or negedge nrst) begin
  if (!nrst) begin
    stat_valid_q <= 1'b0;
    stat_tmo_q   <= 1'b0;
  end else begin
    if (latch_evt_w) begin
      stat_valid_q <= 1'b1;
    end else if (wr_stat_w && wdata[`MPET_STAT_VALID]) begin
      stat_valid_q <= 1'b0;
    end
    if (tmo_evt_w) begin
      stat_tmo_q <= 1'b1;
    end else if (wr_stat_w && wdata[`MPET_STAT_TMO]) begin
      stat_tmo_q <= 1'b0;
    end
  end
end

// Channel state outputs.
always @(posedge clk or negedge nrst) begin
  if (!nrst) begin
    capture_unavailable_q <= 1'b0;
    position_valid_q      <= 1'b0;
  end else begin
    capture_unavailable_q <= echo_mode_w;
    position_valid_q      <= stat_valid_q;
  end
end

////////////////////////////////////////////////////////////////////////////////
// Register reads; data stand one cycle after the strobe, zero otherwise.
always @* begin
  rd_mux_w = 32'h00000000;
  case (addr)
    `MPET_OFF_LATCH: begin
      rd_mux_w = {echo_time_latch_q, `MPET_LATCH_FILL};
    end
    `MPET_OFF_CTRL: begin
      rd_mux_w[`MPET_CTRL_OUTEN]                 = phase_d_output_enable_q;
      rd_mux_w[`MPET_CTRL_TM_HI:`MPET_CTRL_TM_LO] = channel_timer_function_q;
    end
    `MPET_OFF_FMT: begin
      rd_mux_w[3:0] = phase_output_format_q;
    end
    `MPET_OFF_WIDTH: begin
      rd_mux_w[15:0] = pulse_width_setting_q;
    end
    `MPET_OFF_DIV: begin
      rd_mux_w[15:0] = pulse_clock_divider_q;
    end
    `MPET_OFF_FREQ: begin
      rd_mux_w[23:0] = freq_cmd_q;
    end
    `MPET_OFF_STAT: begin
      rd_mux_w[`MPET_STAT_VALID]  = stat_valid_q;
      rd_mux_w[`MPET_STAT_TMO]    = stat_tmo_q;
      rd_mux_w[`MPET_STAT_BUSY]   = counting_q;
      rd_mux_w[`MPET_STAT_NOCAPT] = echo_mode_w;
      rd_mux_w[`MPET_STAT_PULSE]  = pulse_w;
    end
    default: begin
      rd_mux_w = 32'h00000000;
    end
  endcase
end

always @(posedge clk or negedge nrst) begin
  if (!nrst) begin
    rdata_q <= 32'h00000000;
  end else if (rd) begin
    rdata_q <= rd_mux_w;
  end else begin
    rdata_q <= 32'h00000000;
  end
end

endmodule // mpet_pulse_echo_timer

// ===== sim/mpet_pulse_echo_timer_chk.sv
// Assertion checker for the pulse-echo timer channel.
`timescale 1ns/1ns
module mpet_chk (
  // Clock and reset.
  input wire        clk,
  input wire        nrst,
  // Register port.
  input wire [7:0]  addr,
  input wire [31:0] wdata,
  input wire        wr,
  input wire        rd,
  input wire [31:0] rdata_q,
  // Servo strobe and channel outputs.
  input wire        servo_irq,
  input wire        pulse_frequency_output_pos_q,
  input wire        pulse_frequency_output_neg_q,
  input wire        pulse_frequency_output_oe_q,
  input wire        capture_unavailable_q
);
  reg         fmt3_q;
  reg  [15:0] width_q;
  reg  [15:0] div_q;
  reg  [31:0] hi_cnt_q;
  wire [31:0] len_exp = (div_q < 16'h2 ? 32'h1 : {16'h0, div_q}) * {16'h0, width_q};
  wire        fire_ok = fmt3_q && (width_q != 16'h0) && (div_q <= 16'h20);
  ////////////////////////////////////////////////////////////////////////////////
  // Shadow of the pulse settings and a count of the pulse length.
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      fmt3_q   <= 1'b0;
      width_q  <= 16'h5;
      div_q    <= 16'h20;
      hi_cnt_q <= 32'h0;
    end else begin
      if (wr && addr == 8'h08) fmt3_q <= wdata[3];
      if (wr && addr == 8'h0c) width_q <= wdata[15:0];
      if (wr && addr == 8'h10) div_q <= wdata[15:0];
      hi_cnt_q <= pulse_frequency_output_pos_q ? hi_cnt_q + 32'h1 : 32'h0;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Properties.
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence s_fire;
    servo_irq && pulse_frequency_output_oe_q && capture_unavailable_q && fire_ok;
  endsequence
  sequence s_pulse;
    ##[1:40] pulse_frequency_output_pos_q;
  endsequence
  property p_off_quiet;
    !pulse_frequency_output_oe_q |-> !pulse_frequency_output_pos_q && !pulse_frequency_output_neg_q;
  endproperty
  property p_diff;
    pulse_frequency_output_oe_q |-> pulse_frequency_output_pos_q != pulse_frequency_output_neg_q;
  endproperty
  property p_oe_cause;
    $changed(pulse_frequency_output_oe_q) |-> $past(wr) || $past(wr, 2) || $past(wr, 3);
  endproperty
  property p_cap_cause;
    $changed(capture_unavailable_q) |-> $past(wr) || $past(wr, 2) || $past(wr, 3);
  endproperty
  property p_fire;
    s_fire |-> s_pulse;
  endproperty
  property p_width;
    $fell(pulse_frequency_output_pos_q) |-> hi_cnt_q == len_exp;
  endproperty
  property p_rd_idle;
    !$past(rd) |-> rdata_q == 32'h0;
  endproperty
  property p_low_zero;
    rd && addr == 8'h00 |=> rdata_q[7:0] == 8'h00;
  endproperty
  a_off_quiet: assert property (p_off_quiet) else $error("excitation pins driven while disabled");
  a_diff: assert property (p_diff) else $error("excitation pair not complementary");
  a_oe_cause: assert property (p_oe_cause) else $error("output enable changed without a write");
  a_cap_cause: assert property (p_cap_cause) else $error("capture flag changed without a write");
  a_fire: assert property (p_fire) else $error("servo interrupt gave no excitation pulse");
  a_width: assert property (p_width) else $error("excitation pulse length wrong");
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside read answer");
  a_low_zero: assert property (p_low_zero) else $error("latch low byte not zero");
endmodule // mpet_chk
bind mpet_pulse_echo_timer mpet_chk u_mpet_chk (
  .clk                          (clk),
  .nrst                         (nrst),
  .addr                         (addr),
  .wdata                        (wdata),
  .wr                           (wr),
  .rd                           (rd),
  .rdata_q                      (rdata_q),
  .servo_irq                    (servo_irq),
  .pulse_frequency_output_pos_q (pulse_frequency_output_pos_q),
  .pulse_frequency_output_neg_q (pulse_frequency_output_neg_q),
  .pulse_frequency_output_oe_q  (pulse_frequency_output_oe_q),
  .capture_unavailable_q        (capture_unavailable_q)
);

// ===== sim/mpet_xdcr_model.sv
// Behavioural transducer that answers each excitation pulse with one echo, unless silent is set.
`timescale 1ns/1ns
module mpet_xdcr_model (
  // Clock and reset.
  input  wire        clk,
  input  wire        nrst,
  // Excitation pair and its enable.
  input  wire        exc_pos,
  input  wire        exc_neg,
  input  wire        exc_oe,
  // Echo delay in clocks and echo loss.
  input  wire [15:0] delay,
  input  wire        silent,
  // Echo pair.
  output reg         echo_pos,
  output wire        echo_neg
);
  reg        last_q;
  reg        run_q;
  reg [15:0] cnt_q;
  assign echo_neg = ~echo_pos;
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      last_q   <= 1'b0;
      run_q    <= 1'b0;
      cnt_q    <= 16'h0;
      echo_pos <= 1'b0;
    end else begin
      last_q <= exc_pos;
      if (run_q) cnt_q <= cnt_q + 16'h1;
      if (run_q && cnt_q == delay + 16'h4) run_q <= 1'b0;
      if (exc_oe && last_q && !exc_pos && exc_neg && !silent) begin
        run_q <= 1'b1;
        cnt_q <= 16'h0;
      end
      echo_pos <= run_q && cnt_q >= delay && cnt_q < delay + 16'h4;
    end
  end
endmodule // mpet_xdcr_model

// ===== sim/mpet_pulse_echo_timer_tb.sv
// Self-checking testbench for the pulse-echo timer channel.
`timescale 1ns/1ns
module mpet_pulse_echo_timer_tb;
  reg         clk;
  reg         nrst;
  reg  [7:0]  addr;
  reg  [31:0] wdata;
  reg         wr;
  reg         rd;
  reg         servo_irq;
  reg  [15:0] delay;
  reg         silent;
  wire [31:0] rdata_q;
  wire        echo_pos;
  wire        echo_neg;
  wire        exc_pos;
  wire        exc_neg;
  wire        exc_oe;
  wire        cap_na;
  wire        pos_valid;
  integer     num_errors;
  integer     num_checks;
  integer     i;
  integer     rises;
  integer     len;
  reg  [31:0] v;
  reg  [31:0] prev;
  reg  [15:0] dprev;
  reg  [15:0] wid;
  mpet_pulse_echo_timer u_mpet_pulse_echo_timer (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata_q(rdata_q), .servo_irq(servo_irq), .echo_input_pos(echo_pos), .echo_input_neg(echo_neg),
    .pulse_frequency_output_pos_q(exc_pos), .pulse_frequency_output_neg_q(exc_neg),
    .pulse_frequency_output_oe_q(exc_oe), .capture_unavailable_q(cap_na), .position_valid_q(pos_valid));
  mpet_xdcr_model u_mpet_xdcr_model (.clk(clk), .nrst(nrst), .exc_pos(exc_pos), .exc_neg(exc_neg),
    .exc_oe(exc_oe), .delay(delay), .silent(silent), .echo_pos(echo_pos), .echo_neg(echo_neg));
  always #5 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////////////
  // Expectations.
  function [31:0] rst_val(input [7:0] a);
    begin
      case (a)
        8'h0c: rst_val = 32'h5;
        8'h10: rst_val = 32'h20;
        default: rst_val = 32'h0;
      endcase
    end
  endfunction
  function [31:0] echo_diff(input [15:0] d, input [15:0] dp);
    echo_diff = 32'd6 * {16'h0, d} - 32'd6 * {16'h0, dp};
  endfunction
  ////////////////////////////////////////////////////////////////////////////////
  // Bus, strobe, observation and report tasks.
  task check(input [31:0] got, input [31:0] exp);
    begin
      num_checks = num_checks + 1;
      if (got !== exp) begin
        num_errors = num_errors + 1;
        $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task wr_reg(input [7:0] a, input [31:0] d);
    begin
      @(posedge clk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge clk);
      wr    <= 1'b0;
    end
  endtask
  task rd_reg(input [7:0] a, output [31:0] d);
    begin
      @(posedge clk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clk);
      rd   <= 1'b0;
      #1;
      d = rdata_q;
    end
  endtask
  task fire;
    begin
      @(posedge clk);
      servo_irq <= 1'b1;
      @(posedge clk);
      servo_irq <= 1'b0;
    end
  endtask
  task observe(input integer n);
    integer k;
    reg     p;
    begin
      rises = 0;
      len = 0;
      p = exc_pos;
      for (k = 0; k < n; k = k + 1) begin
        @(posedge clk);
        #1;
        if (exc_pos === 1'b1 && !p) rises = rises + 1;
        if (exc_pos === 1'b1) len = len + 1;
        p = exc_pos;
      end
    end
  endtask
  task end_of_test;
    begin
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
    end
  endtask
  initial begin
    #400000;
    num_errors = num_errors + 1;
    end_of_test;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial begin
    clk = 1'b0;
    nrst = 1'b0;
    addr = 8'h0;
    wdata = 32'h0;
    wr = 1'b0;
    rd = 1'b0;
    servo_irq = 1'b0;
    delay = 16'h0;
    silent = 1'b0;
    num_errors = 0;
    num_checks = 0;
    prev = 32'h0;
    dprev = 16'h0;
    v = $urandom(80);
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    for (i = 0; i < 8; i = i + 1) begin
      rd_reg(8'(i * 4), v);
      check(v, rst_val(8'(i * 4)));
    end
    wr_reg(8'h00, 32'hffffffff);
    rd_reg(8'h00, v);
    check(v, 32'h0);
    wr_reg(8'h08, 32'h8);
    wr_reg(8'h04, 32'h2);
    fire;
    observe(300);
    check(rises, 0);
    check(exc_oe, 1'b0);
    check(cap_na, 1'b1);
    wr_reg(8'h04, 32'h3);
    wr_reg(8'h08, $urandom_range(7, 0));
    fire;
    observe(300);
    check(rises, 0);
    check(exc_neg, 1'b1);
    wr_reg(8'h08, 32'h8 + $urandom_range(7, 0));
    wr_reg(8'h14, 32'hffffff);
    observe(300);
    check(rises, 0);
    fire;
    observe(300);
    check(rises, 1);
    check(len, 160);
    wr_reg(8'h10, 32'h1);
    wid = 16'($urandom_range(4, 1));
    wr_reg(8'h0c, {16'h0, wid});
    for (i = 0; i < 7; i = i + 1) begin
      @(posedge clk);
      delay  <= (i == 0) ? 16'h3 : 16'($urandom_range(400, 20));
      silent <= (i == 4);
      fire;
      observe(600);
      check(len, wid);
      rd_reg(8'h00, v);
      check(v[7:0], 8'h00);
      if (silent) check(v, prev);
      else if (i > 0) check(v[31:8] - prev[31:8], echo_diff(delay, dprev));
      if (!silent) begin
        prev = v;
        dprev = delay;
      end
    end
    check(pos_valid, 1'b1);
    rd_reg(8'h18, v);
    check(v, 32'h0000000b);
    wr_reg(8'h18, 32'h3);
    rd_reg(8'h18, v);
    check(v, 32'h00000008);
    wr_reg(8'h04, 32'h1);
    observe(40);
    check(cap_na, 1'b0);
    check(rises > 0, 1'b1);
    @(posedge clk);
    nrst <= 1'b0;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    rd_reg(8'h04, v);
    check(v, 32'h0);
    check(exc_oe, 1'b0);
    end_of_test;
  end
endmodule // mpet_pulse_echo_timer_tb
